// ==== src/slc_regs.sv ====
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module slc_regs #(
  parameter int unsigned LANE_W = 1,
  parameter int unsigned NUM_CFG = 12
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [slc_pkg::SLC_ADDR_W-1:0] paddr,
  input wire logic [slc_pkg::SLC_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [slc_pkg::SLC_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // lane 3 link configuration parameters, one byte each
  input wire logic [NUM_CFG*8-1:0] link_cfg_params,
  // logical lane streams
  input wire logic [slc_pkg::SLC_NUM_LANES*LANE_W-1:0] logical_lanes,
  // physical serial outputs
  output logic [LANE_W-1:0] serial_out_lane_0,
  output logic [LANE_W-1:0] serial_out_lane_1,
  output logic [LANE_W-1:0] serial_out_lane_2,
  output logic [LANE_W-1:0] serial_out_lane_3,
  output logic [LANE_W-1:0] serial_out_lane_4,
  output logic [LANE_W-1:0] serial_out_lane_5,
  output logic [LANE_W-1:0] serial_out_lane_6,
  output logic [LANE_W-1:0] serial_out_lane_7,
  // driver power-down controls
  output logic [slc_pkg::SLC_NUM_LANES-1:0] lane_powerdown
);
  import slc_pkg::*;

  // =====================================================
  // register state
  logic [7:0] csum_q;
  logic [7:0] csum_d;
  logic [7:0] pwrdn_q;
  logic [2:0] map_p0_q;
  logic [2:0] map_p1_q;
  logic [2:0] map_p2_q;
  logic [2:0] map_p3_q;
  logic pready_q;
  logic pslverr_q;
  logic [SLC_DATA_W-1:0] prdata_q;

  // =====================================================
  // address decode
  logic [SLC_IDX_W-1:0] idx;
  logic addr_ok;
  logic hit_csum;
  logic hit_pwrdn;
  logic hit_map01;
  logic hit_map23;
  logic setup;
  logic wr_en;
  logic [7:0] rd_byte;

  assign idx = paddr[SLC_IDX_W+1:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[SLC_ADDR_W-1:SLC_IDX_W+2] == '0);
  assign hit_csum = addr_ok && (idx == SLC_IDX_CSUM3);
  assign hit_pwrdn = addr_ok && (idx == SLC_IDX_PWRDN);
  assign hit_map01 = addr_ok && (idx == SLC_IDX_MAP01);
  assign hit_map23 = addr_ok && (idx == SLC_IDX_MAP23);
  assign setup = psel && !penable;
  // writes land only at the completing access edge; byte lane 0 holds all fields
  assign wr_en = psel && penable && pready_q && pwrite && !pslverr_q && pstrb[0];

  // =====================================================
  // checksum
  always_comb begin
    csum_d = SLC_CSUM_LANE_ID;
    for (int i = 0; i < NUM_CFG; i++) begin
      csum_d = csum_d + link_cfg_params[i*8 +: 8];
    end
  end

  // recomputed every cycle, so it follows the parameters with one cycle of lag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csum_q <= SLC_CSUM3_RST;
    end else begin
      csum_q <= csum_d;
    end
  end

  // =====================================================
  // power-down register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwrdn_q <= SLC_PWRDN_RST;
    end else if (wr_en && hit_pwrdn) begin
      pwrdn_q <= pwdata[7:0];
    end
  end

  // =====================================================
  // lane assignment registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_p0_q <= SLC_MAP_P0_RST;
      map_p1_q <= SLC_MAP_P1_RST;
    end else if (wr_en && hit_map01) begin
      map_p0_q <= pwdata[SLC_MAP_LO_LSB +: SLC_SEL_W];
      map_p1_q <= pwdata[SLC_MAP_HI_LSB +: SLC_SEL_W];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      map_p2_q <= SLC_MAP_P2_RST;
      map_p3_q <= SLC_MAP_P3_RST;
    end else if (wr_en && hit_map23) begin
      map_p2_q <= pwdata[SLC_MAP_LO_LSB +: SLC_SEL_W];
      map_p3_q <= pwdata[SLC_MAP_HI_LSB +: SLC_SEL_W];
    end
  end

  // =====================================================
  // read mux, reserved bits read zero
  always_comb begin
    rd_byte = 8'h00;
    if (hit_csum) begin
      rd_byte = csum_q;
    end else if (hit_pwrdn) begin
      rd_byte = pwrdn_q;
    end else if (hit_map01) begin
      rd_byte = {1'b0, map_p1_q, 1'b0, map_p0_q};
    end else if (hit_map23) begin
      rd_byte = {1'b0, map_p3_q, 1'b0, map_p2_q};
    end
  end

  // =====================================================
  // apb handshake: one access cycle, answer prepared during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= setup;
      // writes to the read-only checksum are dropped silently, not flagged
      pslverr_q <= setup && !(hit_csum || hit_pwrdn || hit_map01 || hit_map23);
      if (setup && !pwrite) begin
        prdata_q <= {24'h000000, rd_byte};
      end else if (setup) begin
        prdata_q <= '0;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign lane_powerdown = pwrdn_q;

  // =====================================================
  // crossbar
  logic [SLC_NUM_LANES*SLC_SEL_W-1:0] sel_all;
  logic [SLC_NUM_LANES*LANE_W-1:0] phys_all;

  // physical lanes 4 to 7 keep their default mapping in this block
  assign sel_all = {SLC_MAP_P7_RST, SLC_MAP_P6_RST, SLC_MAP_P5_RST, SLC_MAP_P4_RST,
                    map_p3_q, map_p2_q, map_p1_q, map_p0_q};

  slc_xbar #(
    .LANE_W(LANE_W)
  ) u_xbar (
    .pclk(pclk),
    .presetn(presetn),
    .logical_lanes(logical_lanes),
    .lane_sel(sel_all),
    .lane_pd(pwrdn_q),
    .phys_lanes(phys_all)
  );

  assign serial_out_lane_0 = phys_all[0*LANE_W +: LANE_W];
  assign serial_out_lane_1 = phys_all[1*LANE_W +: LANE_W];
  assign serial_out_lane_2 = phys_all[2*LANE_W +: LANE_W];
  assign serial_out_lane_3 = phys_all[3*LANE_W +: LANE_W];
  assign serial_out_lane_4 = phys_all[4*LANE_W +: LANE_W];
  assign serial_out_lane_5 = phys_all[5*LANE_W +: LANE_W];
  assign serial_out_lane_6 = phys_all[6*LANE_W +: LANE_W];
  assign serial_out_lane_7 = phys_all[7*LANE_W +: LANE_W];

  // =====================================================
  // assertions
  logic [LANE_W-1:0] pick_p1;
  logic [LANE_W-1:0] pick_p0;

  assign pick_p1 = logical_lanes[int'(map_p1_q)*LANE_W +: LANE_W];
  assign pick_p0 = logical_lanes[int'(map_p0_q)*LANE_W +: LANE_W];

  a_csum_follows: assert property (@(posedge pclk) disable iff (!presetn)
    $stable(link_cfg_params) |=> (csum_q == $past(csum_d)))
    else $error("checksum does not follow parameters");

  a_pd_bit_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (pwrdn_q[3] && $past(pwrdn_q[3])) |-> (serial_out_lane_3 == '0))
    else $error("powered-down lane 3 not quiet");

  a_pd_write_lane: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit_pwrdn) |=> (lane_powerdown == $past(pwdata[7:0])))
    else $error("power-down write not applied per lane");

  a_pd_reset_zero: assert property (@(posedge pclk)
    $rose(presetn) |-> (lane_powerdown == 8'h00))
    else $error("power-down not zero after reset");

  a_map1_field: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit_map01) |=> (map_p1_q == $past(pwdata[6:4])) && (rd_byte[7] == 1'b0))
    else $error("lane 1 assignment not written");

  a_map0_field: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit_map01) |=> (map_p0_q == $past(pwdata[2:0])) [*1])
    else $error("lane 0 assignment not written");

  a_map23_field: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && hit_map23) |=> (map_p3_q == $past(pwdata[6:4])) && (map_p2_q == $past(pwdata[2:0])))
    else $error("lane 2 or 3 assignment not written");

  a_xbar_route: assert property (@(posedge pclk) disable iff (!presetn)
    (!pwrdn_q[1] && !pwrdn_q[0]) |=> (serial_out_lane_1 == $past(pick_p1))
      && (serial_out_lane_0 == $past(pick_p0)))
    else $error("crossbar routed wrong logical lane");

  a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
    setup |=> pready ##1 !pready)
    else $error("apb answer not exactly one cycle");
endmodule : slc_regs

// ==== src/slc_pkg.sv ====
package slc_pkg;
  // =====================================================
  // lane geometry
  localparam int unsigned SLC_NUM_LANES = 8;
  localparam int unsigned SLC_SEL_W = 3;
  localparam logic [7:0] SLC_CSUM_LANE_ID = 8'h03;

  // =====================================================
  // apb geometry
  localparam int unsigned SLC_ADDR_W = 16;
  localparam int unsigned SLC_DATA_W = 32;
  localparam int unsigned SLC_IDX_W = 12;

  // =====================================================
  // register indices, byte address is four times the index
  localparam logic [11:0] SLC_IDX_CSUM3 = 12'h5A3;
  localparam logic [11:0] SLC_IDX_PWRDN = 12'h5B0;
  localparam logic [11:0] SLC_IDX_MAP01 = 12'h5B2;
  localparam logic [11:0] SLC_IDX_MAP23 = 12'h5B3;

  // =====================================================
  // field positions
  localparam int unsigned SLC_MAP_LO_LSB = 0;
  localparam int unsigned SLC_MAP_HI_LSB = 4;

  // =====================================================
  // reset values
  localparam logic [7:0] SLC_CSUM3_RST = 8'hC6;
  localparam logic [7:0] SLC_PWRDN_RST = 8'h00;
  localparam logic [2:0] SLC_MAP_P0_RST = 3'h0;
  localparam logic [2:0] SLC_MAP_P1_RST = 3'h1;
  localparam logic [2:0] SLC_MAP_P2_RST = 3'h2;
  localparam logic [2:0] SLC_MAP_P3_RST = 3'h3;
  localparam logic [2:0] SLC_MAP_P4_RST = 3'h4;
  localparam logic [2:0] SLC_MAP_P5_RST = 3'h5;
  localparam logic [2:0] SLC_MAP_P6_RST = 3'h6;
  localparam logic [2:0] SLC_MAP_P7_RST = 3'h7;
endpackage : slc_pkg

// ==== src/slc_xbar.sv ====
`timescale 1ns/1ps
module slc_xbar #(
  parameter int unsigned LANE_W = 1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // logical lanes, lane k at bits k*LANE_W
  input wire logic [slc_pkg::SLC_NUM_LANES*LANE_W-1:0] logical_lanes,
  // per physical lane selection and power-down
  input wire logic [slc_pkg::SLC_NUM_LANES*slc_pkg::SLC_SEL_W-1:0] lane_sel,
  input wire logic [slc_pkg::SLC_NUM_LANES-1:0] lane_pd,
  // physical lanes
  output logic [slc_pkg::SLC_NUM_LANES*LANE_W-1:0] phys_lanes
);
  import slc_pkg::*;

  logic [LANE_W-1:0] log_arr [SLC_NUM_LANES];

  // =====================================================
  // per lane select and gate
  genvar g;
  generate
    for (g = 0; g < SLC_NUM_LANES; g++) begin : g_lane
      assign log_arr[g] = logical_lanes[g*LANE_W +: LANE_W];
      // a powered-down lane holds zero so the receiver sees no stale data
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          phys_lanes[g*LANE_W +: LANE_W] <= '0;
        end else if (lane_pd[g]) begin
          phys_lanes[g*LANE_W +: LANE_W] <= '0;
        end else begin
          phys_lanes[g*LANE_W +: LANE_W] <= log_arr[lane_sel[g*SLC_SEL_W +: SLC_SEL_W]];
        end
      end
    end
  endgenerate
endmodule : slc_xbar

// ==== test/slc_rx_model.sv ====
`timescale 1ns/1ps
// =====================================================
// far-side receiver: sees the eight serial lanes as plain bits
module slc_rx_model (
  // serial lanes from the transmitter
  input wire logic [7:0] lanes,
  // bits as the receiver sees them
  output logic [7:0] rx_bits
);
  // combinational so that the bench checks the transmitter's own timing
  assign rx_bits = lanes;
endmodule : slc_rx_model

// ==== test/tb.sv ====
`timescale 1ns/1ps
module tb;
  import slc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, err;
  logic [15:0] paddr;
  logic [31:0] pwdata, rd;
  logic [3:0] pstrb;
  wire [31:0] prdata;
  wire pready, pslverr;
  logic [95:0] cfg;
  logic [7:0] ll, pd_s, w01, w23, pd;
  wire [7:0] so, rxb, lane_powerdown;
  logic [2:0] sel [8];
  int miscompares, samples_checked, seed, i, k;
  localparam logic [15:0] A_CS = {2'b00, SLC_IDX_CSUM3, 2'b00};
  localparam logic [15:0] A_PD = {2'b00, SLC_IDX_PWRDN, 2'b00};
  localparam logic [15:0] A_M01 = {2'b00, SLC_IDX_MAP01, 2'b00};
  localparam logic [15:0] A_M23 = {2'b00, SLC_IDX_MAP23, 2'b00};

  slc_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_cfg_params(cfg), .logical_lanes(ll),
    .serial_out_lane_0(so[0]), .serial_out_lane_1(so[1]), .serial_out_lane_2(so[2]),
    .serial_out_lane_3(so[3]), .serial_out_lane_4(so[4]), .serial_out_lane_5(so[5]),
    .serial_out_lane_6(so[6]), .serial_out_lane_7(so[7]), .lane_powerdown(lane_powerdown));
  slc_rx_model rx (.lanes(so), .rx_bits(rxb));

  // =====================================================
  // helpers
  function automatic logic [7:0] exp_sum(input logic [95:0] c);
    logic [7:0] s;
    s = SLC_CSUM_LANE_ID;
    for (int j = 0; j < 12; j++) s = s + c[8*j +: 8];
    return s;
  endfunction : exp_sum

  function automatic logic [7:0] exp_lanes(input logic [7:0] l);
    logic [7:0] r;
    for (int p = 0; p < 8; p++) r[p] = pd_s[p] ? 1'b0 : l[sel[p]];
    return r;
  endfunction : exp_lanes

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input logic [15:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0, 4'hF);
    chk(rd, e);
    chk({31'h0, err}, {31'h0, ee});
  endtask : rchk

  task automatic lchk();
    @(posedge pclk);
    ll <= 8'($random(seed));
    @(posedge pclk);
    #1;
    chk({24'h0, rxb}, {24'h0, exp_lanes(ll)});
    chk({24'h0, lane_powerdown}, {24'h0, pd_s});
  endtask : lchk

  task automatic give_verdict();
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  // =====================================================
  // clock, watchdog, sequence
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    cfg = 96'hC3;
    ll = 8'h00;
    seed = 32'h31dd;
    pd_s = 8'h00;
    for (k = 0; k < 8; k++) sel[k] = 3'(k);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rchk(A_CS, 32'hC6, 1'b0);
    rchk(A_PD, 32'h00, 1'b0);
    rchk(A_M01, 32'h10, 1'b0);
    rchk(A_M23, 32'h32, 1'b0);
    lchk();
    rchk(16'h0004, 32'h0, 1'b1);
    rchk(A_CS | 16'h4000, 32'h0, 1'b1);
    apb(1'b1, A_PD | 16'h0001, 32'hFF, 4'hF);
    apb(1'b1, A_CS, 32'hFF, 4'hF);
    apb(1'b1, A_PD, 32'hFF, 4'h0);
    rchk(A_PD, 32'h00, 1'b0);
    rchk(A_CS, 32'hC6, 1'b0);
    for (i = 0; i < 20; i++) begin
      cfg <= {$random(seed), $random(seed), $random(seed)};
      w01 = (i == 0) ? 8'h77 : 8'($random(seed));
      w23 = (i == 1) ? 8'h88 : 8'($random(seed));
      pd = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
      apb(1'b1, A_M01, {24'h0, w01}, 4'hF);
      apb(1'b1, A_M23, {24'h0, w23}, 4'hF);
      apb(1'b1, A_PD, {24'h0, pd}, 4'hF);
      {sel[1], sel[0], sel[3], sel[2]} = {w01[6:4], w01[2:0], w23[6:4], w23[2:0]};
      pd_s = pd;
      rchk(A_M01, {24'h0, w01 & 8'h77}, 1'b0);
      rchk(A_M23, {24'h0, w23 & 8'h77}, 1'b0);
      rchk(A_PD, {24'h0, pd}, 1'b0);
      rchk(A_CS, {24'h0, exp_sum(cfg)}, 1'b0);
      repeat (3) lchk();
    end
    // second reset in mid-run must restore every default
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    chk({24'h0, lane_powerdown}, 32'h0);
    chk({24'h0, rxb}, 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    pd_s = 8'h00;
    for (k = 0; k < 8; k++) sel[k] = 3'(k);
    rchk(A_M01, 32'h10, 1'b0);
    lchk();
    give_verdict();
  end
endmodule : tb
